// [logic/dctm_pkg.sv]
package dctm_pkg;
	localparam int unsigned CW = 16;
	localparam int unsigned PW = 8;
	localparam logic [CW-1:0] COUNT_RESET = 16'hffff;
	localparam logic [CW-1:0] LOAD_RESET = 16'hffff;
	localparam logic [PW-1:0] PRESCALE_RESET = 8'h00;
	localparam int unsigned RTC_DIVIDE = 32768;
	// register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_MODE_A = 8'h04;
	localparam logic [7:0] OFF_MODE_B = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_LOAD_A = 8'h18;
	localparam logic [7:0] OFF_LOAD_B = 8'h1c;
	localparam logic [7:0] OFF_MATCH_A = 8'h20;
	localparam logic [7:0] OFF_MATCH_B = 8'h24;
	localparam logic [7:0] OFF_PRE_A = 8'h28;
	localparam logic [7:0] OFF_PRE_B = 8'h2c;
	localparam logic [7:0] OFF_COUNT_A = 8'h30;
	localparam logic [7:0] OFF_COUNT_B = 8'h34;
	// mode register fields
	localparam int unsigned MODE_CAP_TIME = 2;
	localparam int unsigned MODE_PWM = 3;
	// control register, one byte per half
	localparam int unsigned CTL_STRIDE = 8;
	localparam int unsigned CTL_EN = 0;
	localparam int unsigned CTL_STALL = 1;
	localparam int unsigned CTL_EVT = 2;
	localparam int unsigned CTL_OTE = 4;
	localparam int unsigned CTL_PINV = 5;
	// status bits, three per half at a stride of four, plus rtc in half a
	localparam int unsigned ST_STRIDE = 4;
	localparam int unsigned ST_TIMEOUT = 0;
	localparam int unsigned ST_MATCH = 1;
	localparam int unsigned ST_CAPTURE = 2;
	localparam int unsigned ST_RTC = 3;
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;
	localparam logic [1:0] EVT_BOTH = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned LAST_PIN_BLOCK = 2;
	typedef enum logic [2:0] {
		DCTM_CFG_JOIN  = 3'h0,
		DCTM_CFG_RTC   = 3'h1,
		DCTM_CFG_SPLIT = 3'h4
	} dctm_cfg_type;
	typedef enum logic [1:0] {
		DCTM_MODE_OFF      = 2'h0,
		DCTM_MODE_ONESHOT  = 2'h1,
		DCTM_MODE_PERIODIC = 2'h2,
		DCTM_MODE_CAPTURE  = 2'h3
	} dctm_mode_type;
endpackage

// [logic/dctm_timer.sv]
// Function
// - two 16-bit halves, separate or joined 32-bit
// - joined configuration runs only as 32-bit
// - halves take independent modes from mode registers
// - per-half match, prescale and load registers
// - reset leaves block inactive, controls cleared
// - reset sets counters and loads to ffff
// - reset clears prescale counters and registers
// - trigger outputs ORed into one converter trigger
// - rtc counts 32.768 kHz edges on even pin
// - prescaler only in split one-shot and periodic modes, not with pwm
// - stall bit freezes counting during debug halt, except in rtc config
// - each half counts or timestamps pin edges
// - simple pwm with invertible output polarity
// - pins used only when alternate function selected
// - config 0 joined timer, 1 rtc
// - config 4 runs halves independently
// - joined access puts half b above half a
`timescale 1ns/1ps
module dctm_timer
	import dctm_pkg::*;
#(
	parameter int unsigned block_index = 0,
	parameter int unsigned rtc_divide  = RTC_DIVIDE
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic [1:0]  capture_pin_in,
	output logic [1:0]       capture_pin_out,
	output logic [1:0]       capture_pin_oe,
	input  wire logic [1:0]  alt_function_select,
	input  wire logic        debug_halt,
	input  wire logic        other_adc_trigger,
	output logic             adc_trigger,
	output logic             irq
);
	localparam logic HAS_PINS = (block_index <= LAST_PIN_BLOCK);
	localparam logic [14:0] RTC_LAST = 15'(rtc_divide - 1);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic edge_hit(input logic rise, input logic fall, input logic [1:0] sel);
		return (sel == EVT_BOTH) ? (rise | fall) : (sel == EVT_FALL) ? fall : rise;
	endfunction

	logic [2:0]    cfg, next_cfg;
	logic [3:0]    mode [2], next_mode [2];
	logic [15:0]   ctl, next_ctl;
	logic [7:0]    mask, next_mask, status, next_status;
	logic [CW-1:0] count [2], next_count [2], load [2], next_load [2];
	logic [CW-1:0] match [2], next_match [2], cap [2], next_cap [2];
	logic [PW-1:0] pre_reg [2], next_pre_reg [2], pre_cnt [2], next_pre_cnt [2];
	logic [14:0]   rtc_div, next_rtc_div;
	logic [1:0]    pwm_q, next_pwm_q;
	logic          trig_q, next_trig_q;
	logic [1:0]    sync1, sync2, prev;
	logic [1:0]    rise, fall;
	logic          joined, wr;
	logic [31:0]   wv;

	logic       aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic       next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;

	// pins pass two flops; the first stage feeds nothing else
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			prev  <= 2'h0;
		end else begin
			sync1 <= capture_pin_in;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	always_comb begin
		for (int h = 0; h < 2; h++) begin
			rise[h] = HAS_PINS && alt_function_select[h] && sync2[h] && !prev[h];
			fall[h] = HAS_PINS && alt_function_select[h] && !sync2[h] && prev[h];
		end
	end

	assign joined = (cfg == DCTM_CFG_JOIN) || (cfg == DCTM_CFG_RTC);
	assign wr = aw_held && w_held && !bvalid;

	always_comb begin
		logic [31:0] c32;
		logic        ev;
		int          cb;
		c32 = {count[1], count[0]};
		ev = 1'b0;
		cb = 0;
		next_cfg = cfg;
		next_ctl = ctl;
		next_mask = mask;
		next_rtc_div = rtc_div;
		next_trig_q = 1'b0;
		next_status = status;
		wv = 32'h0;
		for (int h = 0; h < 2; h++) begin
			next_mode[h] = mode[h];
			next_count[h] = count[h];
			next_load[h] = load[h];
			next_match[h] = match[h];
			next_cap[h] = cap[h];
			next_pre_reg[h] = pre_reg[h];
			next_pre_cnt[h] = pre_cnt[h];
			next_pwm_q[h] = (count[h] >= match[h]) ^ ctl[h*CTL_STRIDE+CTL_PINV];
		end
		if (cfg == DCTM_CFG_JOIN) begin
			if (ctl[CTL_EN] && !(ctl[CTL_STALL] && debug_halt) &&
			    (mode[0][1:0] == DCTM_MODE_ONESHOT || mode[0][1:0] == DCTM_MODE_PERIODIC)) begin
				if (c32 == 32'h0) begin
					c32 = {load[1], load[0]};
					next_status[ST_TIMEOUT] = 1'b1;
					next_trig_q = ctl[CTL_OTE];
					if (mode[0][1:0] == DCTM_MODE_ONESHOT) begin
						next_ctl[CTL_EN] = 1'b0;
					end
				end else begin
					c32 = c32 - 32'h1;
				end
			end
			{next_count[1], next_count[0]} = c32;
		end else if (cfg == DCTM_CFG_RTC) begin
			// stall is ignored here: wall time keeps running under debug
			if (ctl[CTL_EN] && rise[0]) begin
				if (rtc_div == RTC_LAST) begin
					next_rtc_div = 15'h0;
					if (c32 == {match[1], match[0]}) begin
						c32 = 32'h0;
						next_status[ST_RTC] = 1'b1;
					end else begin
						c32 = c32 + 32'h1;
					end
				end else begin
					next_rtc_div = rtc_div + 15'h1;
				end
			end
			{next_count[1], next_count[0]} = c32;
		end else begin
			for (int h = 0; h < 2; h++) begin
				cb = h * CTL_STRIDE;
				ev = edge_hit(rise[h], fall[h], ctl[cb+CTL_EVT +: 2]);
				if (ctl[cb+CTL_EN] && !(ctl[cb+CTL_STALL] && debug_halt)) begin
					case (mode[h][1:0])
						DCTM_MODE_ONESHOT, DCTM_MODE_PERIODIC: begin
							if (mode[h][MODE_PWM]) begin
								next_count[h] = (count[h] == 16'h0) ? load[h] : count[h] - 16'h1;
							end else if (pre_cnt[h] != 8'h0) begin
								next_pre_cnt[h] = pre_cnt[h] - 8'h1;
							end else if (count[h] == 16'h0) begin
								next_count[h] = load[h];
								next_pre_cnt[h] = pre_reg[h];
								next_status[h*ST_STRIDE+ST_TIMEOUT] = 1'b1;
								next_trig_q = next_trig_q | ctl[cb+CTL_OTE];
								if (mode[h][1:0] == DCTM_MODE_ONESHOT) begin
									next_ctl[cb+CTL_EN] = 1'b0;
								end
							end else begin
								next_count[h] = count[h] - 16'h1;
								next_pre_cnt[h] = pre_reg[h];
							end
						end
						DCTM_MODE_CAPTURE: begin
							if (mode[h][MODE_CAP_TIME]) begin
								next_count[h] = (count[h] == 16'h0) ? load[h] : count[h] - 16'h1;
								if (ev) begin
									next_cap[h] = count[h];
									next_status[h*ST_STRIDE+ST_CAPTURE] = 1'b1;
								end
							end else if (ev) begin
								if (count[h] == match[h]) begin
									next_count[h] = load[h];
									next_ctl[cb+CTL_EN] = 1'b0;
									next_status[h*ST_STRIDE+ST_MATCH] = 1'b1;
								end else begin
									next_count[h] = count[h] - 16'h1;
								end
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
		if (wr) begin
			if (aw_addr == OFF_CONFIG) begin
				wv = merge({29'h0, cfg}, w_data, w_strb);
				next_cfg = wv[2:0];
				if (wv[2:0] == DCTM_CFG_RTC && cfg != DCTM_CFG_RTC) begin
					next_count[0] = 16'h1;
					next_count[1] = 16'h0;
					next_rtc_div = 15'h0;
				end
			end else if (aw_addr == OFF_MODE_A) begin
				wv = merge({28'h0, mode[0]}, w_data, w_strb);
				next_mode[0] = wv[3:0];
			end else if (aw_addr == OFF_MODE_B) begin
				wv = merge({28'h0, mode[1]}, w_data, w_strb);
				next_mode[1] = wv[3:0];
			end else if (aw_addr == OFF_CONTROL) begin
				wv = merge({16'h0, ctl}, w_data, w_strb);
				next_ctl = wv[15:0];
			end else if (aw_addr == OFF_MASK) begin
				wv = merge({24'h0, mask}, w_data, w_strb);
				next_mask = wv[7:0];
			end else if (aw_addr == OFF_LOAD_A && joined) begin
				wv = merge({load[1], load[0]}, w_data, w_strb);
				{next_load[1], next_load[0]} = wv;
				{next_count[1], next_count[0]} = wv;
			end else if (aw_addr == OFF_LOAD_A || aw_addr == OFF_LOAD_B) begin
				cb = (aw_addr == OFF_LOAD_B) ? 1 : 0;
				wv = merge({16'h0, load[cb]}, w_data, w_strb);
				next_load[cb] = wv[15:0];
				next_count[cb] = wv[15:0];
			end else if (aw_addr == OFF_MATCH_A && joined) begin
				wv = merge({match[1], match[0]}, w_data, w_strb);
				{next_match[1], next_match[0]} = wv;
			end else if (aw_addr == OFF_MATCH_A || aw_addr == OFF_MATCH_B) begin
				cb = (aw_addr == OFF_MATCH_B) ? 1 : 0;
				wv = merge({16'h0, match[cb]}, w_data, w_strb);
				next_match[cb] = wv[15:0];
			end else if (aw_addr == OFF_PRE_A || aw_addr == OFF_PRE_B) begin
				cb = (aw_addr == OFF_PRE_B) ? 1 : 0;
				wv = merge({24'h0, pre_reg[cb]}, w_data, w_strb);
				next_pre_reg[cb] = wv[7:0];
				next_pre_cnt[cb] = wv[7:0];
			end
		end
		// new events on a clear bit win over a write-one clear in the same cycle
		if (wr && aw_addr == OFF_STATUS && w_strb[0]) begin
			next_status = (next_status & ~w_data[7:0]) | (next_status & ~status);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= DCTM_CFG_JOIN;
			ctl <= 16'h0;
			mask <= 8'h0;
			status <= 8'h0;
			rtc_div <= 15'h0;
			pwm_q <= 2'h0;
			trig_q <= 1'b0;
			for (int h = 0; h < 2; h++) begin
				mode[h] <= 4'h0;
				count[h] <= COUNT_RESET;
				load[h] <= LOAD_RESET;
				match[h] <= 16'h0;
				cap[h] <= 16'h0;
				pre_reg[h] <= PRESCALE_RESET;
				pre_cnt[h] <= PRESCALE_RESET;
			end
		end else begin
			cfg <= next_cfg;
			ctl <= next_ctl;
			mask <= next_mask;
			status <= next_status;
			rtc_div <= next_rtc_div;
			pwm_q <= next_pwm_q;
			trig_q <= next_trig_q;
			for (int h = 0; h < 2; h++) begin
				mode[h] <= next_mode[h];
				count[h] <= next_count[h];
				load[h] <= next_load[h];
				match[h] <= next_match[h];
				cap[h] <= next_cap[h];
				pre_reg[h] <= next_pre_reg[h];
				pre_cnt[h] <= next_pre_cnt[h];
			end
		end
	end

	always_comb begin
		for (int h = 0; h < 2; h++) begin
			capture_pin_oe[h] = HAS_PINS && alt_function_select[h] && !joined &&
			                    mode[h][MODE_PWM] && mode[h][1:0] != DCTM_MODE_CAPTURE;
		end
	end
	assign capture_pin_out = pwm_q;
	assign adc_trigger = trig_q | other_adc_trigger;
	assign irq = |(status & mask);

	// bus slave: address and data held until both have arrived
	assign awready = !aw_held && !bvalid;
	assign wready = !w_held && !bvalid;
	assign arready = !rvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid && !bready;
		next_bresp = bresp;
		next_rvalid = rvalid && !rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = {awaddr[7:2], 2'h0};
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (wr) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_addr > OFF_COUNT_B) ? RESP_SLVERR : RESP_OKAY;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			if (araddr[7:2] == OFF_CONFIG[7:2]) begin
				next_rdata = {29'h0, cfg};
			end else if (araddr[7:2] == OFF_MODE_A[7:2]) begin
				next_rdata = {28'h0, mode[0]};
			end else if (araddr[7:2] == OFF_MODE_B[7:2]) begin
				next_rdata = {28'h0, mode[1]};
			end else if (araddr[7:2] == OFF_CONTROL[7:2]) begin
				next_rdata = {16'h0, ctl};
			end else if (araddr[7:2] == OFF_MASK[7:2]) begin
				next_rdata = {24'h0, mask};
			end else if (araddr[7:2] == OFF_STATUS[7:2]) begin
				next_rdata = {24'h0, status};
			end else if (araddr[7:2] == OFF_LOAD_A[7:2]) begin
				next_rdata = joined ? {load[1], load[0]} : {16'h0, load[0]};
			end else if (araddr[7:2] == OFF_LOAD_B[7:2]) begin
				next_rdata = {16'h0, load[1]};
			end else if (araddr[7:2] == OFF_MATCH_A[7:2]) begin
				next_rdata = joined ? {match[1], match[0]} : {16'h0, match[0]};
			end else if (araddr[7:2] == OFF_MATCH_B[7:2]) begin
				next_rdata = {16'h0, match[1]};
			end else if (araddr[7:2] == OFF_PRE_A[7:2]) begin
				next_rdata = {24'h0, pre_reg[0]};
			end else if (araddr[7:2] == OFF_PRE_B[7:2]) begin
				next_rdata = {24'h0, pre_reg[1]};
			end else if (araddr[7:2] == OFF_COUNT_A[7:2]) begin
				next_rdata = joined ? {count[1], count[0]} : {16'h0, mode[0][MODE_CAP_TIME] ? cap[0] : count[0]};
			end else if (araddr[7:2] == OFF_COUNT_B[7:2]) begin
				next_rdata = {16'h0, mode[1][MODE_CAP_TIME] ? cap[1] : count[1]};
			end else begin
				next_rdata = 32'h0;
				next_rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h0;
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	property p_reset_counts;
		@(posedge aclk) !aresetn |=> count[0] == COUNT_RESET && count[1] == COUNT_RESET &&
		                             load[0] == LOAD_RESET && load[1] == LOAD_RESET;
	endproperty
	a_reset_counts: assert property (p_reset_counts) else $error("counters not ffff after reset");

	property p_reset_prescale;
		@(posedge aclk) !aresetn |=> pre_cnt[0] == 8'h0 && pre_cnt[1] == 8'h0 && pre_reg[0] == 8'h0 && pre_reg[1] == 8'h0;
	endproperty
	a_reset_prescale: assert property (p_reset_prescale) else $error("prescale not cleared after reset");

	property p_reset_idle;
		@(posedge aclk) !aresetn |=> ctl == 16'h0 && capture_pin_oe == 2'h0 && !irq && !trig_q;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("block active after reset");

	property p_joined_no_pins;
		@(posedge aclk) disable iff (!aresetn) joined |-> capture_pin_oe == 2'h0;
	endproperty
	a_joined_no_pins: assert property (p_joined_no_pins) else $error("half driven in joined mode");

	property p_alt_gate;
		@(posedge aclk) disable iff (!aresetn) (capture_pin_oe & ~alt_function_select) == 2'h0;
	endproperty
	a_alt_gate: assert property (p_alt_gate) else $error("pin driven without alternate function");

	property p_no_prescale_capture;
		@(posedge aclk) disable iff (!aresetn)
			!joined && mode[0][1:0] == DCTM_MODE_CAPTURE && !wr |=> $stable(pre_cnt[0]);
	endproperty
	a_no_prescale_capture: assert property (p_no_prescale_capture) else $error("prescaler moved in capture");

	property p_stall;
		@(posedge aclk) disable iff (!aresetn)
			cfg != DCTM_CFG_RTC && ctl[CTL_STALL] && debug_halt && !wr
			|=> $stable(count[0]) && (cfg != DCTM_CFG_JOIN || $stable(count[1]));
	endproperty
	a_stall: assert property (p_stall) else $error("counter moved during debug stall");

	property p_trigger_or;
		@(posedge aclk) disable iff (!aresetn)
			$past(next_trig_q) || other_adc_trigger |-> adc_trigger;
	endproperty
	a_trigger_or: assert property (p_trigger_or) else $error("converter trigger lost");

	property p_rtc_entry;
		@(posedge aclk) disable iff (!aresetn)
			wr && aw_addr == OFF_CONFIG && w_strb[0] && w_data[2:0] == DCTM_CFG_RTC && cfg != DCTM_CFG_RTC
			|=> cfg == DCTM_CFG_RTC && {count[1], count[0]} == 32'h1;
	endproperty
	a_rtc_entry: assert property (p_rtc_entry) else $error("rtc entry did not preload one");
endmodule // dctm_timer

// [sim/dctm_far_end.sv]
`timescale 1ns/1ps
module dctm_far_end (
	input  wire logic aclk,
	output logic [1:0] ext_level,
	output logic       other_adc_trigger
);
	initial begin
		ext_level = 2'h0;
		other_adc_trigger = 1'b0;
	end
	// three cycles per level, above the one-cycle minimum of the edge detector
	task automatic edges(input int pin, input int n);
		repeat (n) begin
			ext_level[pin] <= 1'b1;
			repeat (3) @(posedge aclk);
			ext_level[pin] <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
	task automatic trig(input logic v);
		other_adc_trigger <= v;
	endtask
endmodule // dctm_far_end

// [sim/dual_counter_timer_module_tb.sv]
`timescale 1ns/1ps
module dual_counter_timer_module_tb;
	import dctm_pkg::*;
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [31:0] mask;
		logic [1:0]  resp;
	} dctm_exp_type;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, adc_trigger;
	logic        debug_halt, other_adc_trigger, trig_seen;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, ext_level, pin_wire, capture_pin_out, capture_pin_oe, alt_function_select;
	int          miscompares = 0;
	int          comparisons = 0;
	int          highs;
	dctm_exp_type rq[$];
	dctm_exp_type bq[$];
	dctm_exp_type reset_tab[7] = '{
		'{OFF_CONFIG, 32'h0, 32'h7, RESP_OKAY}, '{OFF_CONTROL, 32'h0, 32'hffff, RESP_OKAY},
		'{OFF_LOAD_A, 32'hffffffff, 32'hffffffff, RESP_OKAY}, '{OFF_COUNT_A, 32'hffffffff, 32'hffffffff, RESP_OKAY},
		'{OFF_PRE_A, 32'h0, 32'hff, RESP_OKAY}, '{OFF_PRE_B, 32'h0, 32'hff, RESP_OKAY},
		'{OFF_STATUS, 32'h0, 32'hff, RESP_OKAY}};

	always #12.5 aclk = ~aclk;
	// undriven pin follows the far side
	assign pin_wire = (capture_pin_oe & capture_pin_out) | (~capture_pin_oe & ext_level);

	dctm_timer #(.block_index(0), .rtc_divide(4)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .capture_pin_in(pin_wire),
		.capture_pin_out(capture_pin_out), .capture_pin_oe(capture_pin_oe),
		.alt_function_select(alt_function_select), .debug_halt(debug_halt),
		.other_adc_trigger(other_adc_trigger), .adc_trigger(adc_trigger), .irq(irq));
	dctm_far_end i_far (.aclk(aclk), .ext_level(ext_level), .other_adc_trigger(other_adc_trigger));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// handshakes judged at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = RESP_OKAY);
		logic aw_p, w_p, b_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		b_p = 1'b1;
		bq.push_back('{a, v, 32'h0, e});
		// a free edge keeps the previous release apart from this request
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_p || w_p) begin
			@(negedge aclk);
			if (awvalid && awready) aw_p = 1'b0;
			if (wvalid && wready) w_p = 1'b0;
			@(posedge aclk);
			awvalid <= aw_p;
			wvalid <= w_p;
		end
		while (b_p) begin
			@(negedge aclk);
			if (bvalid) b_p = 1'b0;
			@(posedge aclk);
			bready <= b_p;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
			input logic [1:0] e = RESP_OKAY);
		logic ar_p, r_p;
		ar_p = 1'b1;
		r_p = 1'b1;
		rq.push_back('{a, v, m, e});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (r_p) begin
			@(negedge aclk);
			if (arvalid && arready) ar_p = 1'b0;
			if (rvalid) r_p = 1'b0;
			@(posedge aclk);
			arvalid <= ar_p;
			rready <= r_p;
		end
	endtask
	task automatic wait_irq;
		int n;
		n = 0;
		trig_seen = 1'b0;
		while (irq !== 1'b1 && n < 400) begin
			@(negedge aclk);
			trig_seen = trig_seen | adc_trigger;
			n++;
		end
		@(posedge aclk);
	endtask
	task automatic count_highs(input int n);
		highs = 0;
		repeat (n) begin
			@(negedge aclk);
			if (capture_pin_out[0] === 1'b1) highs++;
		end
		@(posedge aclk);
	endtask

	always @(negedge aclk) begin
		dctm_exp_type x;
		if (rvalid && rready && rq.size() > 0) begin
			x = rq.pop_front();
			chk("rdata", x.data & x.mask, rdata & x.mask);
			chk("rresp", 32'(x.resp), 32'(rresp));
		end
		if (bvalid && bready && bq.size() > 0) begin
			x = bq.pop_front();
			chk("bresp", 32'(x.resp), 32'(bresp));
		end
	end

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		wrap_up();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, debug_halt} = 7'h0;
		{awaddr, araddr, wdata, alt_function_select} = 50'h0;
		wstrb = 4'hf;
		void'($urandom(32'h7620be38));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (reset_tab[i]) rd(reset_tab[i].addr, reset_tab[i].data, reset_tab[i].mask);
		@(negedge aclk);
		chk("irq", 32'h0, 32'(irq));
		chk("oe", 32'h0, 32'(capture_pin_oe));
		@(posedge aclk);
		rd(8'h38, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h3c, 32'h5a, RESP_SLVERR);
		d = $urandom;
		wr(OFF_LOAD_A, d);
		rd(OFF_LOAD_A, d, 32'hffffffff);
		rd(OFF_COUNT_A, d, 32'hffffffff);
		// split halves: A periodic with prescale, B one-shot
		wr(OFF_CONFIG, 32'(DCTM_CFG_SPLIT));
		rd(OFF_LOAD_A, {16'h0, d[15:0]}, 32'hffff);
		rd(OFF_LOAD_B, {16'h0, d[31:16]}, 32'hffff);
		wr(OFF_MODE_A, 32'(DCTM_MODE_PERIODIC));
		wr(OFF_MODE_B, 32'(DCTM_MODE_ONESHOT));
		wr(OFF_LOAD_A, 32'h3);
		wr(OFF_LOAD_B, 32'h5);
		wr(OFF_PRE_A, 32'h2);
		wr(OFF_MASK, 32'h1);
		wr(OFF_CONTROL, 32'h111);
		wait_irq();
		chk("irq", 32'h1, 32'(irq));
		chk("trigger", 32'h1, 32'(trig_seen));
		rd(OFF_STATUS, 32'h11, 32'h11);
		rd(OFF_CONTROL, 32'h0, 32'h100);
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_STATUS, 32'h1);
		rd(OFF_STATUS, 32'h10, 32'h11);
		@(negedge aclk);
		chk("irq", 32'h0, 32'(irq));
		@(posedge aclk);
		wr(OFF_STATUS, 32'h10);
		i_far.trig(1'b1);
		@(negedge aclk);
		chk("adc_trigger", 32'h1, 32'(adc_trigger));
		@(posedge aclk);
		i_far.trig(1'b0);
		// pwm: 9-state period, high while count >= match
		wr(OFF_PRE_A, 32'h0);
		wr(OFF_MODE_A, 32'h0a);
		wr(OFF_LOAD_A, 32'h8);
		wr(OFF_MATCH_A, 32'h4);
		wr(OFF_CONTROL, 32'h01);
		@(negedge aclk);
		chk("oe", 32'h0, 32'(capture_pin_oe));
		@(posedge aclk);
		alt_function_select <= 2'h1;
		repeat (2) @(posedge aclk);
		count_highs(18);
		chk("oe", 32'h1, 32'(capture_pin_oe));
		chk("pwm highs", 32'd10, 32'(highs));
		wr(OFF_CONTROL, 32'h21);
		repeat (2) @(posedge aclk);
		count_highs(18);
		chk("pwm inverted highs", 32'd8, 32'(highs));
		// frozen while halted
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_MODE_A, 32'(DCTM_MODE_PERIODIC));
		wr(OFF_LOAD_A, 32'h1234);
		debug_halt <= 1'b1;
		wr(OFF_CONTROL, 32'h03);
		repeat (5) @(posedge aclk);
		rd(OFF_COUNT_A, 32'h1234, 32'hffff);
		debug_halt <= 1'b0;
		wr(OFF_CONTROL, 32'h0);
		// edge count: 5 down to match 3 takes three falling edges
		wr(OFF_MODE_A, 32'(DCTM_MODE_CAPTURE));
		wr(OFF_LOAD_A, 32'h5);
		wr(OFF_MATCH_A, 32'h3);
		wr(OFF_CONTROL, 32'h05);
		i_far.edges(0, 3);
		rd(OFF_STATUS, 32'h2, 32'h2);
		rd(OFF_CONTROL, 32'h0, 32'h1);
		wr(OFF_STATUS, 32'h2);
		wr(OFF_MODE_A, 32'h7);
		wr(OFF_CONTROL, 32'h01);
		i_far.edges(0, 1);
		rd(OFF_STATUS, 32'h4, 32'h4);
		// rtc: one count per four rising pin edges with the shortened divider
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_CONFIG, 32'(DCTM_CFG_RTC));
		wr(OFF_MATCH_A, 32'h2);
		wr(OFF_CONTROL, 32'h01);
		i_far.edges(0, 12);
		rd(OFF_STATUS, 32'h8, 32'h8);
		// joined one-shot: 3 down to 0, reload, enable cleared
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_CONFIG, 32'(DCTM_CFG_JOIN));
		wr(OFF_MODE_A, 32'(DCTM_MODE_ONESHOT));
		wr(OFF_LOAD_A, 32'h3);
		wr(OFF_CONTROL, 32'h11);
		wait_irq();
		chk("joined trigger", 32'h1, 32'(trig_seen));
		rd(OFF_CONTROL, 32'h0, 32'h1);
		rd(OFF_COUNT_A, 32'h3, 32'hffffffff);
		repeat (2) @(posedge aclk);
		wrap_up();
	end
endmodule // dual_counter_timer_module_tb
